// ---- host_port_pkg.sv ----
// Shared constants and carriers for the host port select decoder.
// Assumes a single 50 MHz clock domain and an asynchronous active-low reset.
package host_port_pkg;

    localparam int unsigned CLK_PERIOD_NS     = 20;
    localparam int unsigned HW_RESET_MIN_US   = 10;
    localparam int unsigned HW_RESET_MIN_CYC  =
        (HW_RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W         = 10;

    localparam int unsigned ADDR_W            = 11;
    localparam int unsigned DATA_W            = 8;
    localparam int unsigned REG_IDX_W         = 8;
    localparam int unsigned SEL_MSB           = 10;
    localparam int unsigned SEL_LSB           = 8;
    localparam int unsigned NUM_DOWNSTREAM    = 5;

    localparam logic [2:0] SEL_CODE_MASTER    = 3'h0;
    localparam logic [2:0] SEL_CODE_FIRST     = 3'h1;
    localparam logic [2:0] SEL_CODE_LAST      = 3'h5;
    localparam logic [2:0] SEL_CODE_RESERVED  = 3'h6;
    localparam logic [2:0] SEL_CODE_ALL       = 3'h7;

    localparam logic [2:0] STYLE_ASYNC_A      = 3'h0;
    localparam logic [2:0] STYLE_ASYNC_B      = 3'h1;
    localparam logic [2:0] STYLE_SYNC         = 3'h7;

    localparam logic [DATA_W-1:0] REG_RESET_VAL = 8'h00;
    localparam logic [NUM_DOWNSTREAM-1:0] SEL_N_IDLE = 5'h1f;

    typedef enum logic [2:0] {
        BUS_ASYNC_A = 3'b001,
        BUS_ASYNC_B = 3'b010,
        BUS_SYNC    = 3'b100
    } bus_style_e;

    typedef struct packed {
        logic                 write;
        logic [REG_IDX_W-1:0] index;
        logic [DATA_W-1:0]    wdata;
    } reg_access_s;

endpackage

// ---- host_sync2.sv ----
// Two-flop synchroniser, one per bit of a bus.
// Assumes the input comes from outside the clk domain.
`timescale 1ns/1ps
module host_sync2 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= INIT;
            q        <= INIT;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ---- host_port_select_decoder.sv ----
// Host parallel port front end: address decode, downstream selects,
// bus style strap, data bus steering and hardware reset qualification.
// Assumes the host pins are asynchronous to clk and are synchronised here;
// register storage sits in a small local array standing in for the core.
`timescale 1ns/1ps

// How it works
// - Code 000 self, 001-101 one downstream select
// - Code 111 selects all; 110 selects nobody
// - Low eight address bits index registers directly
// - Data bus driven only during reads
// - Style strap 000, 001 async, 111 sync
// - Reset held over 10 us restores defaults
// - Five selects from top address bits, gated by host select
// - One host select fans out to six devices
// - Sync style times writes from host clock; reads follow rd_n level
module host_port_select_decoder
    import host_port_pkg::*;
(
    // Clock and reset
    input  wire logic                             clk,
    input  wire logic                             rstn,
    // Host pins
    input  wire logic                             host_sel_n,
    input  wire logic                             host_rd_n,
    input  wire logic                             host_wr_n,
    input  wire logic                             host_clk,
    input  wire logic                             hw_reset_n,
    input  wire logic [host_port_pkg::ADDR_W-1:0] host_addr,
    input  wire logic [host_port_pkg::DATA_W-1:0] host_data_in,
    output logic      [host_port_pkg::DATA_W-1:0] host_data_out,
    output logic                                  host_data_oe,
    input  wire logic [2:0]                       host_bus_style_select,
    // Downstream selects
    output logic                                  downstream_select_1,
    output logic                                  downstream_select_2,
    output logic                                  downstream_select_3,
    output logic                                  downstream_select_4,
    output logic                                  downstream_select_5,
    // Core side
    output host_port_pkg::reg_access_s            reg_access,
    output logic                                  reg_write_pulse,
    output logic                                  regs_defaulted,
    output logic                                  style_invalid
);
    import host_port_pkg::*;

    localparam int unsigned SYNC_W = ADDR_W + DATA_W + 3 + 5;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] wdata_s;
    logic [2:0]        style_s;
    logic              sel_n_s;
    logic              rd_n_s;
    logic              wr_n_s;
    logic              hclk_s;
    logic              hrst_n_s;

    // All host pins cross into clk through two flops
    assign pins_raw = {host_addr, host_data_in, host_bus_style_select,
                       host_sel_n, host_rd_n, host_wr_n, host_clk, hw_reset_n};

    host_sync2 #(
        .WIDTH (SYNC_W),
        // Host clock pin idles low, so its edge detector sees no false edge at reset
        .INIT  ({{(SYNC_W-5){1'b0}}, 5'h1d})
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (pins_raw),
        .q    (pins_s)
    );

    assign {addr_s, wdata_s, style_s, sel_n_s, rd_n_s, wr_n_s, hclk_s, hrst_n_s} = pins_s;

    // Style strap is caught once after reset release, not under the async reset
    bus_style_e style_reg;
    logic [1:0] style_wait_reg;
    logic       style_bad_reg;
    bus_style_e style_next;
    logic       style_bad_next;

    always_comb begin
        style_next     = BUS_ASYNC_A;
        style_bad_next = 1'b0;
        case (style_s)
            STYLE_ASYNC_A: style_next = BUS_ASYNC_A;
            STYLE_ASYNC_B: style_next = BUS_ASYNC_B;
            STYLE_SYNC:    style_next = BUS_SYNC;
            default:       style_bad_next = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            style_reg      <= BUS_ASYNC_A;
            style_wait_reg <= 2'h0;
            style_bad_reg  <= 1'b0;
        end else if (style_wait_reg != 2'h3) begin
            // Wait for the synchroniser to fill; its reset value is not the strap
            style_wait_reg <= style_wait_reg + 2'h1;
            if (style_wait_reg == 2'h2) begin
                style_reg     <= style_next;
                style_bad_reg <= style_bad_next;
            end
        end
    end

    // Address decode
    wire [2:0] sel_code   = addr_s[SEL_MSB:SEL_LSB];
    wire       port_on    = !sel_n_s;
    wire       self_hit   = port_on && (sel_code == SEL_CODE_MASTER
                                        || sel_code == SEL_CODE_ALL);
    wire [REG_IDX_W-1:0] reg_idx = addr_s[REG_IDX_W-1:0];

    logic [NUM_DOWNSTREAM-1:0] ds_sel_n_next;
    always_comb begin
        ds_sel_n_next = SEL_N_IDLE;
        for (int i = 0; i < NUM_DOWNSTREAM; i++) begin
            // One host select reaches up to six devices
            if (port_on && (sel_code == SEL_CODE_ALL
                            || sel_code == 3'(i + 1))) begin
                ds_sel_n_next[i] = 1'b0;
            end
        end
    end

    // Strobe qualification per bus style
    logic hw_reset_act;
    logic hclk_d_reg;
    logic wr_n_d_reg;
    wire  hclk_rise = hclk_s && !hclk_d_reg;
    wire  wr_rise   = wr_n_s && !wr_n_d_reg;
    // Async A: separate read and write strobes, active low
    // Async B: rd_n pin acts as read-not-write, wr_n as data strobe
    // Sync: host_clk edge with wr_n as write enable
    wire  rd_active = (style_reg == BUS_ASYNC_A) ? !rd_n_s :
                      (style_reg == BUS_ASYNC_B) ? (rd_n_s && !wr_n_s) :
                                                   (!rd_n_s && wr_n_s);
    wire  wr_event  = (style_reg == BUS_SYNC) ? (hclk_rise && !wr_n_s) :
                      (style_reg == BUS_ASYNC_B) ? (wr_rise && !rd_n_s) :
                                                   wr_rise;
    wire  do_write  = self_hit && wr_event && !style_bad_reg && !hw_reset_act;
    wire  do_read   = self_hit && rd_active && !style_bad_reg;

    // Hardware reset must be held longer than the minimum before it counts
    logic [RST_CNT_W-1:0] rst_cnt_reg;
    assign hw_reset_act = (rst_cnt_reg > RST_CNT_W'(HW_RESET_MIN_CYC));
    wire [RST_CNT_W-1:0] rst_cnt_next =
        hrst_n_s ? '0 : (hw_reset_act ? rst_cnt_reg : rst_cnt_reg + 1'b1);

    // Register space, indexed straight by the low address bits
    logic [DATA_W-1:0] regs_mem [0:(1<<REG_IDX_W)-1];

    always_ff @(posedge clk) begin
        if (hw_reset_act) begin
            for (int i = 0; i < (1 << REG_IDX_W); i++) begin
                regs_mem[i] <= REG_RESET_VAL;
            end
        end else if (do_write) begin
            regs_mem[reg_idx] <= wdata_s;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt_reg <= '0;
            hclk_d_reg  <= 1'b0;
            wr_n_d_reg  <= 1'b1;
        end else begin
            rst_cnt_reg <= rst_cnt_next;
            hclk_d_reg  <= hclk_s;
            wr_n_d_reg  <= wr_n_s;
        end
    end

    // Outputs all registered; selects idle high so nothing floats low at reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            downstream_select_1 <= 1'b1;
            downstream_select_2 <= 1'b1;
            downstream_select_3 <= 1'b1;
            downstream_select_4 <= 1'b1;
            downstream_select_5 <= 1'b1;
            host_data_out       <= '0;
            host_data_oe        <= 1'b0;
            reg_access          <= '0;
            reg_write_pulse     <= 1'b0;
            regs_defaulted      <= 1'b0;
            style_invalid       <= 1'b0;
        end else begin
            downstream_select_1 <= ds_sel_n_next[0];
            downstream_select_2 <= ds_sel_n_next[1];
            downstream_select_3 <= ds_sel_n_next[2];
            downstream_select_4 <= ds_sel_n_next[3];
            downstream_select_5 <= ds_sel_n_next[4];
            // Bus turns around one clock late; host must not drive while reading
            host_data_oe        <= do_read;
            host_data_out       <= regs_mem[reg_idx];
            reg_access          <= '{write: do_write, index: reg_idx, wdata: wdata_s};
            reg_write_pulse     <= do_write;
            regs_defaulted      <= hw_reset_act;
            style_invalid       <= style_bad_reg;
        end
    end
endmodule

// ---- host_port_select_decoder_checker.sv ----
// Port checker for the host select decoder, bound into it.
// Assumes host pins are held steady at least four cycles around changes.
`timescale 1ns/1ps
module host_port_select_decoder_checker
    import host_port_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // Host pins
    input wire logic              host_sel_n,
    input wire logic              hw_reset_n,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [DATA_W-1:0] host_data_in,
    input wire logic              host_data_oe,
    // Selects
    input wire logic              downstream_select_1,
    input wire logic              downstream_select_2,
    input wire logic              downstream_select_3,
    input wire logic              downstream_select_4,
    input wire logic              downstream_select_5,
    // Core side
    input wire reg_access_s       reg_access,
    input wire logic              reg_write_pulse,
    input wire logic              regs_defaulted
);
    logic [4:0] ds;
    logic [2:0] code;
    logic [7:0] idx;
    logic [4:0] want;
    logic [9:0] low_cnt;
    assign ds = {downstream_select_5, downstream_select_4, downstream_select_3,
                 downstream_select_2, downstream_select_1};
    assign code = host_addr[10:8];
    assign idx = host_addr[7:0];
    assign want = (code == 3'h7) ? 5'h00 :
                  (code >= 3'h1 && code <= 3'h5) ? ~(5'h01 << (code - 3'h1)) : 5'h1f;
    // Saturates so a very long reset cannot wrap back into range
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            low_cnt <= 10'h000;
        else
            low_cnt <= hw_reset_n ? 10'h000 : low_cnt + {9'h000, low_cnt != 10'h3ff};
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence held_sel;
        (!host_sel_n && $stable(host_addr))[*4];
    endsequence
    sequence idle_sel;
        host_sel_n[*4];
    endsequence
    sel_decode_a: assert property (held_sel |-> ds == want)
        else $error("select decode wrong");
    sel_idle_a: assert property (idle_sel |-> ds == 5'h1f)
        else $error("select active while port idle");
    write_code_a: assert property (reg_write_pulse |-> $past(code, 4) inside {3'h0, 3'h7})
        else $error("write taken for another device");
    write_index_a: assert property (reg_write_pulse |-> reg_access.index == $past(idx, 4))
        else $error("register index wrong");
    write_data_a: assert property (reg_write_pulse |-> reg_access.write
        && reg_access.wdata == $past(host_data_in, 4)) else $error("write data wrong");
    read_drive_a: assert property (host_data_oe |-> !$past(host_sel_n, 3)
        && $past(code, 3) inside {3'h0, 3'h7}) else $error("data bus driven outside read");
    hold_qualify_a: assert property ($rose(regs_defaulted) |-> low_cnt >= 10'h1f4)
        else $error("short reset restored defaults");
    hold_restore_a: assert property (low_cnt == 10'h1fe |-> regs_defaulted)
        else $error("long reset not honoured");
endmodule
bind host_port_select_decoder host_port_select_decoder_checker chk (.clk, .rstn,
    .host_sel_n, .hw_reset_n, .host_addr, .host_data_in, .host_data_oe,
    .downstream_select_1, .downstream_select_2, .downstream_select_3,
    .downstream_select_4, .downstream_select_5, .reg_access, .reg_write_pulse,
    .regs_defaulted);

// ---- host_far_side.sv ----
// Far side: the shared data wire and the five cascaded devices.
// Assumes the bench plays the host processor itself.
`timescale 1ns/1ps
module host_far_side (
    // Data wire
    input  wire logic       host_drive,
    input  wire logic [7:0] host_wdata,
    input  wire logic       dev_oe,
    input  wire logic [7:0] dev_data,
    output logic      [7:0] bus,
    output logic            clash,
    // Cascaded devices
    input  wire logic [4:0] ds_n,
    output logic      [4:0] picked
);
    // Pull-down wins when nobody drives, so a stale byte never survives
    assign bus = dev_oe ? dev_data : (host_drive ? host_wdata : 8'h00);
    assign clash = dev_oe & host_drive;
    assign picked = ~ds_n;
endmodule

// ---- host_port_select_decoder_test.sv ----
// Self-checking bench for the host select decoder.
// Assumes the far side model and the bound checker are compiled first.
`timescale 1ns/1ps
module host_port_select_decoder_test;
    import host_port_pkg::*;
    logic        clk = 0, rstn = 0, sel_n = 1, rd_n = 1, wr_n = 1, hclk = 0, hw_n = 1;
    logic        drive = 0, oe, pulse, dflt, clash, bad;
    logic [10:0] addr = '0;
    logic [7:0]  wdata = '0, bus, dout;
    logic [2:0]  style = STYLE_ASYNC_A;
    logic [4:0]  ds_n, picked;
    logic [2:0]  kinds [4] = '{STYLE_ASYNC_B, STYLE_SYNC, 3'h3, STYLE_ASYNC_A};
    reg_access_s acc;
    int          num_errors = 0, checked = 0, cyc = 0, seed = 32'h7c72da37;
    host_port_select_decoder dut (.clk, .rstn, .host_sel_n(sel_n), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_clk(hclk), .hw_reset_n(hw_n), .host_addr(addr),
        .host_data_in(bus), .host_data_out(dout), .host_data_oe(oe),
        .host_bus_style_select(style), .downstream_select_1(ds_n[0]),
        .downstream_select_2(ds_n[1]), .downstream_select_3(ds_n[2]),
        .downstream_select_4(ds_n[3]), .downstream_select_5(ds_n[4]),
        .reg_access(acc), .reg_write_pulse(pulse), .regs_defaulted(dflt), .style_invalid(bad));
    host_far_side far (.host_drive(drive), .host_wdata(wdata), .dev_oe(oe), .dev_data(dout),
        .bus, .clash, .ds_n, .picked);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            complete_run;
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [4:0] exp_sel(input logic [2:0] c);
        if (c == 3'h7) return 5'h00;
        if (c == 3'h0 || c == 3'h6) return 5'h1f;
        return ~(5'h01 << (c - 3'h1));
    endfunction
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic restart(input logic [2:0] s);
        style = s;
        rstn = 0;
        hold(2);
        rstn = 1;
        hold(4);
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic exp);
        logic got;
        got = 0;
        addr = a;
        wdata = d;
        drive = 1;
        sel_n = 0;
        rd_n = (style != STYLE_ASYNC_B);
        wr_n = 0;
        hold(4);
        check({3'h0, ds_n}, {3'h0, exp_sel(a[10:8])});
        check({3'h0, picked}, {3'h0, ~exp_sel(a[10:8])});
        if (style == STYLE_SYNC) hclk = 1;
        else wr_n = 1;
        for (int i = 0; i < 8 && !got; i++) begin
            hold(1);
            got = (pulse === 1'b1);
        end
        check({7'h0, got}, {7'h0, exp});
        if (got) check(acc.index, a[7:0]);
        if (got) check(acc.wdata, d);
        hclk = 0;
        wr_n = 1;
        sel_n = 1;
        drive = 0;
        rd_n = 1;
        hold(4);
    endtask
    task automatic rd(input logic [10:0] a, input logic [7:0] d);
        addr = a;
        sel_n = 0;
        rd_n = (style == STYLE_ASYNC_B);
        wr_n = (style != STYLE_ASYNC_B);
        hold(5);
        check({7'h0, oe}, 8'h01);
        check(bus, d);
        rd_n = 1;
        wr_n = 1;
        sel_n = 1;
        hold(4);
        check({7'h0, oe | clash}, 8'h00);
    endtask
    task automatic complete_run;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        logic [10:0] a;
        restart(STYLE_ASYNC_A);
        // Every code once, with the top register index as the boundary case
        for (int c = 0; c < 8; c++) wr({c[2:0], 8'hff}, 8'h3c, c == 0 || c == 7);
        rd(11'h0ff, 8'h3c);
        for (int n = 0; n < 40; n++) begin
            a = 11'($random(seed));
            wr(a, a[7:0] ^ 8'h5a, a[10:8] == 3'h0 || a[10:8] == 3'h7);
            if (a[10:8] == 3'h0 || a[10:8] == 3'h7) rd(a, a[7:0] ^ 8'h5a);
        end
        addr = 11'h700;
        hold(4);
        check({3'h0, ds_n}, 8'h1f);
        wr(11'h003, 8'h5a, 1'b1);
        hw_n = 0;
        hold(400);
        check({7'h0, dflt}, 8'h00);
        hw_n = 1;
        hold(4);
        rd(11'h003, 8'h5a);
        hw_n = 0;
        hold(520);
        check({7'h0, dflt}, 8'h01);
        hw_n = 1;
        hold(6);
        rd(11'h003, REG_RESET_VAL);
        foreach (kinds[k]) begin
            restart(kinds[k]);
            check({7'h0, bad}, {7'h0, kinds[k] == 3'h3});
            wr(11'h011, 8'h96, kinds[k] != 3'h3);
            if (kinds[k] != 3'h3) rd(11'h011, 8'h96);
        end
        complete_run;
    end
endmodule
